// ### core/status_led_regs.vh
// Timing and encoding constants for the status indicator logic
`ifndef STATUS_LED_REGS_VH
`define STATUS_LED_REGS_VH
`define CLK_HZ 10000000
`define TICK_US 1000
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)
`define FLASH_HALF_MS 250
`define ERR_PULSE_MS 200
`define ERR_PAUSE_MS 1000
`define ERR_CODE_W 3
`define ERR_CODE_UNRECOV 3'h4
`define ERR_CODE_HOST 3'h3
`define ERR_CODE_FW 3'h2
`define ERR_CODE_RESET 3'h1
`define ERR_CODE_NOIP 3'h0
`define ERR_UNRECOV_FLASHES 4
`define MOD_OFF 3'h0
`define MOD_SELFTEST 3'h1
`define MOD_STANDBY 3'h2
`define MOD_OPER 3'h3
`define MOD_FAULT_REC 3'h4
`define MOD_FAULT_UNREC 3'h5
`endif

// ### core/linking_device_status_leds.v
// Status indicator logic for the Ethernet-to-fieldbus linking device
`timescale 1ns/1ns
`default_nettype none
`include "status_led_regs.vh"
module linking_device_status_leds #(
  parameter PORTS = 2,
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter FLASH_HALF_TICKS = `FLASH_HALF_MS,
  parameter ERR_PULSE_TICKS = `ERR_PULSE_MS,
  parameter ERR_PAUSE_TICKS = `ERR_PAUSE_MS,
  parameter UNRECOV_FLASHES = `ERR_UNRECOV_FLASHES
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire power_good_i,
  input wire flash_write_i,
  input wire no_ip_i,
  input wire reset_mode_i,
  input wire fw_error_i,
  input wire host_lost_i,
  input wire unrecov_error_i,
  input wire eth_tx_i,
  input wire eth_rx_i,
  input wire eth_link_i,
  input wire self_test_i,
  input wire self_test_pass_i,
  input wire net_configured_i,
  input wire major_rec_fault_i,
  input wire major_unrec_fault_i,
  input wire [PORTS-1:0] port_rx_i,
  input wire [PORTS-1:0] port_active_link_scheduler_i,
  input wire [PORTS-1:0] port_visitor_addr_i,
  input wire [PORTS-1:0] port_transient_err_i,
  input wire [PORTS-1:0] port_fatal_err_i,
  output reg power_led_o,
  output reg process_led_o,
  output reg error_led_o,
  output reg tx_led_o,
  output reg rx_led_o,
  output reg link_led_o,
  output reg mod_red_o,
  output reg mod_green_o,
  output reg [PORTS-1:0] port_red_o,
  output reg [PORTS-1:0] port_green_o
);

  localparam S_PULSE_ON = 2'h0;
  localparam S_PULSE_OFF = 2'h1;
  localparam S_PAUSE = 2'h2;

  // Pin-level inputs are asynchronous to clk_i, so all pass two flops
  // Reset clears both stages so no stale level reaches a lamp
  localparam NIN = 15 + 5 * PORTS;
  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] sync1_ff;
  reg [NIN-1:0] sync2_ff;
  assign raw_in = {port_fatal_err_i, port_transient_err_i,
    port_visitor_addr_i, port_active_link_scheduler_i, port_rx_i,
    major_unrec_fault_i, major_rec_fault_i, net_configured_i,
    self_test_pass_i, self_test_i, eth_link_i, eth_rx_i, eth_tx_i,
    unrecov_error_i, host_lost_i, fw_error_i, reset_mode_i, no_ip_i,
    flash_write_i, power_good_i};

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync1_ff <= {NIN{1'b0}};
      sync2_ff <= {NIN{1'b0}};
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  wire s_pwr = sync2_ff[0];
  wire s_flash = sync2_ff[1];
  wire s_noip = sync2_ff[2];
  wire s_rstmode = sync2_ff[3];
  wire s_fw = sync2_ff[4];
  wire s_host = sync2_ff[5];
  wire s_unrec = sync2_ff[6];
  wire s_tx = sync2_ff[7];
  wire s_rx = sync2_ff[8];
  wire s_link = sync2_ff[9];
  wire s_test = sync2_ff[10];
  wire s_pass = sync2_ff[11];
  wire s_cfg = sync2_ff[12];
  wire s_frec = sync2_ff[13];
  wire s_funrec = sync2_ff[14];
  wire [PORTS-1:0] s_prx = sync2_ff[15 +: PORTS];
  wire [PORTS-1:0] s_plas = sync2_ff[15 + PORTS +: PORTS];
  wire [PORTS-1:0] s_pvis = sync2_ff[15 + 2 * PORTS +: PORTS];
  wire [PORTS-1:0] s_ptr = sync2_ff[15 + 3 * PORTS +: PORTS];
  wire [PORTS-1:0] s_pfat = sync2_ff[15 + 4 * PORTS +: PORTS];

  // Millisecond tick from a divider keeps the whole block on one clock
  // Tick stays a one-cycle enable; every flash counter steps on it
  reg [15:0] div_ff;
  reg tick_ff;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (div_ff == TICK_CYCLES[15:0] - 16'h0001) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  // Shared blink phase for all plain flashing patterns
  // Limitation: every flashing module and port lamp shares this phase, so all blink together
  reg [15:0] blink_cnt_ff;
  reg blink_ff;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      blink_cnt_ff <= 16'h0000;
      blink_ff <= 1'b0;
    end else if (tick_ff) begin
      if (blink_cnt_ff == FLASH_HALF_TICKS[15:0] - 16'h0001) begin
        blink_cnt_ff <= 16'h0000;
        blink_ff <= ~blink_ff;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 16'h0001;
      end
    end
  end

  // Priority: most severe error class wins when several are present
  reg [2:0] err_code;
  reg err_any;
  always @* begin
    err_code = `ERR_CODE_NOIP;
    err_any = 1'b1;
    if (s_unrec) begin
      err_code = `ERR_CODE_UNRECOV;
    end else if (s_host) begin
      err_code = `ERR_CODE_HOST;
    end else if (s_fw) begin
      err_code = `ERR_CODE_FW;
    end else if (s_rstmode) begin
      err_code = `ERR_CODE_RESET;
    end else if (s_noip) begin
      err_code = `ERR_CODE_NOIP;
    end else begin
      err_any = 1'b0;
    end
  end

  wire [3:0] flash_total = (err_code == `ERR_CODE_UNRECOV) ?
    UNRECOV_FLASHES[3:0] : {1'b0, err_code};

  // Error flash sequencer; the code is latched per sequence so it ends clean
  reg [1:0] err_st_ff;
  reg [15:0] err_cnt_ff;
  reg [3:0] flash_num_ff;
  reg [3:0] flash_goal_ff;
  reg err_lamp;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      err_st_ff <= S_PAUSE;
      err_cnt_ff <= 16'h0000;
      flash_num_ff <= 4'h0;
      flash_goal_ff <= 4'h0;
    end else if (tick_ff) begin
      err_cnt_ff <= err_cnt_ff + 16'h0001;
      case (err_st_ff)
        S_PULSE_ON: begin
          if (err_cnt_ff == ERR_PULSE_TICKS[15:0] - 16'h0001) begin
            err_cnt_ff <= 16'h0000;
            err_st_ff <= S_PULSE_OFF;
          end
        end
        S_PULSE_OFF: begin
          if (err_cnt_ff == ERR_PULSE_TICKS[15:0] - 16'h0001) begin
            err_cnt_ff <= 16'h0000;
            flash_num_ff <= flash_num_ff + 4'h1;
            if (flash_num_ff + 4'h1 >= flash_goal_ff) begin
              err_st_ff <= S_PAUSE;
            end else begin
              err_st_ff <= S_PULSE_ON;
            end
          end
        end
        S_PAUSE: begin
          if (err_cnt_ff >= ERR_PAUSE_TICKS[15:0] - 16'h0001) begin
            err_cnt_ff <= 16'h0000;
            flash_num_ff <= 4'h0;
            flash_goal_ff <= flash_total;
            if (flash_total != 4'h0) begin
              err_st_ff <= S_PULSE_ON;
            end
          end
        end
        default: begin
          err_st_ff <= S_PAUSE;
          err_cnt_ff <= 16'h0000;
        end
      endcase
    end
  end

  // Code 0 lights at once; flashing codes follow the sequencer
  always @* begin
    err_lamp = 1'b0;
    if (err_any) begin
      if (flash_total == 4'h0) begin
        err_lamp = 1'b1;
      end else begin
        err_lamp = (err_st_ff == S_PULSE_ON);
      end
    end
  end

  // Module status state selection
  // Self-test shows while the test runs and until pass is seen, so a failed test never reads standby
  reg [2:0] mod_state;
  always @* begin
    mod_state = `MOD_OFF;
    if (!s_pwr) begin
      mod_state = `MOD_OFF;
    end else if (s_funrec) begin
      mod_state = `MOD_FAULT_UNREC;
    end else if (s_frec) begin
      mod_state = `MOD_FAULT_REC;
    end else if (s_test || !s_pass) begin
      mod_state = `MOD_SELFTEST;
    end else if (s_cfg) begin
      mod_state = `MOD_OPER;
    end else begin
      mod_state = `MOD_STANDBY;
    end
  end

  reg nxt_mod_red;
  reg nxt_mod_green;
  always @* begin
    nxt_mod_red = 1'b0;
    nxt_mod_green = 1'b0;
    case (mod_state)
      `MOD_SELFTEST: begin
        nxt_mod_red = blink_ff;
        nxt_mod_green = ~blink_ff;
      end
      `MOD_STANDBY: nxt_mod_green = blink_ff;
      `MOD_OPER: nxt_mod_green = 1'b1;
      `MOD_FAULT_REC: nxt_mod_red = blink_ff;
      `MOD_FAULT_UNREC: nxt_mod_red = 1'b1;
      default: begin
        nxt_mod_red = 1'b0;
        nxt_mod_green = 1'b0;
      end
    endcase
  end

  // Fatal error outranks the no-traffic off state so it is never hidden
  function [1:0] port_lamp;
    input fatal;
    input rx;
    input transient;
    input visitor;
    input sched;
    input blink;
    if (fatal) begin
      port_lamp = 2'b10;
    end else if (!rx) begin
      port_lamp = 2'b00;
    end else if (transient) begin
      port_lamp = {blink, 1'b0};
    end else if (visitor) begin
      port_lamp = {blink, ~blink};
    end else if (sched) begin
      port_lamp = 2'b01;
    end else begin
      port_lamp = {1'b0, blink};
    end
  endfunction

  wire [PORTS-1:0] nxt_port_red;
  wire [PORTS-1:0] nxt_port_green;
  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi = gi + 1) begin : g_port
      // Each port decodes only its own flags, so ports stay independent
      assign {nxt_port_red[gi], nxt_port_green[gi]} = port_lamp(
        s_pfat[gi], s_prx[gi], s_ptr[gi], s_pvis[gi], s_plas[gi], blink_ff);
    end
  endgenerate

  // Every lamp leaves a flop so no decode glitch reaches a pin
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      power_led_o <= 1'b0;
      process_led_o <= 1'b0;
      error_led_o <= 1'b0;
      tx_led_o <= 1'b0;
      rx_led_o <= 1'b0;
      link_led_o <= 1'b0;
      mod_red_o <= 1'b0;
      mod_green_o <= 1'b0;
      port_red_o <= {PORTS{1'b0}};
      port_green_o <= {PORTS{1'b0}};
    end else begin
      power_led_o <= s_pwr;
      process_led_o <= s_flash;
      error_led_o <= err_lamp;
      tx_led_o <= s_tx;
      rx_led_o <= s_rx;
      link_led_o <= s_link;
      mod_red_o <= nxt_mod_red;
      mod_green_o <= nxt_mod_green;
      port_red_o <= nxt_port_red;
      port_green_o <= nxt_port_green;
    end
  end

endmodule // linking_device_status_leds
`default_nettype wire

// ### sim/led_status_checker_assertions.sv
// Port-level assertions for the status indicator block
`timescale 1ns/1ns
`default_nettype none
module led_status_checker #(
  parameter PORTS = 2
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic power_good_i,
  input wire logic flash_write_i,
  input wire logic no_ip_i,
  input wire logic reset_mode_i,
  input wire logic fw_error_i,
  input wire logic host_lost_i,
  input wire logic unrecov_error_i,
  input wire logic major_unrec_fault_i,
  input wire logic [PORTS-1:0] port_rx_i,
  input wire logic [PORTS-1:0] port_fatal_err_i,
  input wire logic power_led_o,
  input wire logic process_led_o,
  input wire logic error_led_o,
  input wire logic mod_red_o,
  input wire logic mod_green_o,
  input wire logic [PORTS-1:0] port_red_o,
  input wire logic [PORTS-1:0] port_green_o
);
  // Keeps $past off samples taken before reset let go
  logic [2:0] up_ff;
  logic ok;
  assign ok = up_ff == 3'h7;
  always_ff @(posedge clk_i) begin
    up_ff <= !reset_n_i ? 3'h0 : ok ? up_ff : up_ff + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_power;
    ok |-> power_led_o == $past(power_good_i, 3);
  endproperty
  a_power: assert property (p_power)
    else $error("power lamp wrong");
  property p_process;
    ok |-> process_led_o == $past(flash_write_i, 3);
  endproperty
  a_process: assert property (p_process)
    else $error("process lamp wrong");
  property p_no_ip;
    ok && $past(no_ip_i && !reset_mode_i && !fw_error_i && !host_lost_i
      && !unrecov_error_i, 3) |-> error_led_o;
  endproperty
  a_no_ip: assert property (p_no_ip)
    else $error("error lamp not steady");
  property p_mod_off;
    ok && !$past(power_good_i, 3) |-> !mod_red_o && !mod_green_o;
  endproperty
  a_mod_off: assert property (p_mod_off)
    else $error("module lamp lit unpowered");
  property p_mod_unrec;
    ok && $past(power_good_i && major_unrec_fault_i, 3)
      |-> mod_red_o && !mod_green_o;
  endproperty
  a_mod_unrec: assert property (p_mod_unrec)
    else $error("module lamp not solid red");
  property p_port_fatal;
    ok && $past(port_fatal_err_i[PORTS-1], 3)
      |-> port_red_o[PORTS-1] && !port_green_o[PORTS-1];
  endproperty
  a_port_fatal: assert property (p_port_fatal)
    else $error("port lamp not steady red");
  property p_port_off;
    ok && $past(!port_rx_i[0] && !port_fatal_err_i[0], 3)
      |-> !port_red_o[0] && !port_green_o[0];
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("idle port lamp lit");
  // Eight cycles holds only for the short tick counts the bench uses
  property p_err_pulse;
    ok && $rose(error_led_o) && !$past(no_ip_i, 3)
      |-> error_led_o [*8] ##1 !error_led_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse)
    else $error("error pulse width wrong");
  c_err: cover property ($rose(error_led_o));
  c_alt: cover property (mod_red_o && !mod_green_o ##1 mod_green_o);
  c_port: cover property (port_green_o[0] && !port_red_o[0]);
endmodule // led_status_checker
bind linking_device_status_leds led_status_checker #(.PORTS(PORTS))
  i_led_status_checker (.*);
`default_nettype wire

// ### sim/linking_device_status_leds_tb.sv
// Self-checking bench for the status indicator block
`timescale 1ns/1ns
`default_nettype none
module linking_device_status_leds_tb;
  logic clk_i = 0, reset_n_i = 0, power_good_i = 0, flash_write_i = 0;
  logic no_ip_i = 0, reset_mode_i = 0, fw_error_i = 0, host_lost_i = 0;
  logic unrecov_error_i = 0, eth_tx_i = 0, eth_rx_i = 0, eth_link_i = 0;
  logic self_test_i = 0, self_test_pass_i = 0, net_configured_i = 0;
  logic major_rec_fault_i = 0, major_unrec_fault_i = 0;
  logic [1:0] port_rx_i = 0, port_active_link_scheduler_i = 0;
  logic [1:0] port_visitor_addr_i = 0, port_transient_err_i = 0;
  logic [1:0] port_fatal_err_i = 0, port_red_o, port_green_o;
  logic power_led_o, process_led_o, error_led_o, tx_led_o, rx_led_o;
  logic link_led_o, mod_red_o, mod_green_o;
  int num_errors = 0;
  int compares = 0;
  logic [4:0] eth_leds;
  assign eth_leds = {power_led_o, process_led_o, tx_led_o, rx_led_o,
    link_led_o};
  localparam logic [1:0] OF = 2'h1, ON = 2'h2, FL = 2'h3;
  always #50 clk_i = ~clk_i;
  // Short tick and flash counts keep every pattern to tens of cycles
  linking_device_status_leds #(.PORTS(2), .TICK_CYCLES(4),
    .FLASH_HALF_TICKS(2), .ERR_PULSE_TICKS(2), .ERR_PAUSE_TICKS(5))
    i_linking_device_status_leds (.*);
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  // Per colour 01 off, 10 lit, 11 flashing; top bit if colours ever match
  task automatic look(input int w, input logic [4:0] exp);
    logic r, g;
    logic [4:0] s;
    s = 5'h0;
    step(6);
    repeat (40) begin
      @(negedge clk_i);
      r = w == 0 ? mod_red_o : w == 3 ? error_led_o : port_red_o[w == 2];
      g = w == 0 ? mod_green_o : w == 3 ? 1'b0 : port_green_o[w == 2];
      s = s | {r === g, r, !r, g, !g};
    end
    chk(s, exp);
    @(posedge clk_i);
  endtask
  // Dark spells of 12 cycles mark the pause between sequences
  task automatic flashes(input logic [4:0] exp);
    logic [4:0] n;
    int d;
    n = 5'h0;
    d = 0;
    while (d < 12) begin
      @(negedge clk_i);
      d = error_led_o ? 0 : d + 1;
    end
    while (d < 12 || n == 5'h0) begin
      @(negedge clk_i);
      if (error_led_o && d > 0) n = n + 5'h1;
      d = error_led_o ? 0 : d + 1;
    end
    chk(n, exp);
    @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    step(20000);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    step(16);
    reset_n_i <= 1'b1;
    look(0, {1'b1, OF, OF});
    @(negedge clk_i);
    chk(eth_leds, 5'h00);
    @(posedge clk_i);
    power_good_i <= 1'b1;
    flash_write_i <= 1'b1;
    eth_tx_i <= 1'b1;
    eth_rx_i <= 1'b1;
    eth_link_i <= 1'b1;
    step(6);
    @(negedge clk_i);
    chk(eth_leds, 5'h1f);
    @(posedge clk_i);
    {flash_write_i, eth_tx_i, eth_rx_i} <= 3'h0;
    step(6);
    @(negedge clk_i);
    chk(eth_leds, 5'h11);
    @(posedge clk_i);
    look(0, {1'b0, FL, FL});
    self_test_i <= 1'b1;
    self_test_pass_i <= 1'b1;
    look(0, {1'b0, FL, FL});
    self_test_i <= 1'b0;
    look(0, {1'b1, OF, FL});
    net_configured_i <= 1'b1;
    look(0, {1'b0, OF, ON});
    major_rec_fault_i <= 1'b1;
    look(0, {1'b1, FL, OF});
    major_unrec_fault_i <= 1'b1;
    look(0, {1'b0, ON, OF});
    port_rx_i <= 2'h1;
    port_active_link_scheduler_i <= 2'h1;
    look(1, {1'b0, OF, ON});
    look(2, {1'b1, OF, OF});
    port_active_link_scheduler_i <= 2'h0;
    look(1, {1'b1, OF, FL});
    port_visitor_addr_i <= 2'h1;
    look(1, {1'b0, FL, FL});
    port_transient_err_i <= 2'h1;
    look(1, {1'b1, FL, OF});
    port_fatal_err_i <= 2'h2;
    look(2, {1'b0, ON, OF});
    look(1, {1'b1, FL, OF});
    look(3, {1'b1, OF, OF});
    no_ip_i <= 1'b1;
    look(3, {1'b0, ON, OF});
    no_ip_i <= 1'b0;
    // Classes pile up so each pass after the first also checks the priority order
    for (int i = 1; i <= 4; i++) begin
      {unrecov_error_i, host_lost_i, fw_error_i, reset_mode_i} <=
        4'((1 << i) - 1);
      flashes(5'(i));
    end
    tally_and_finish();
  end
endmodule // linking_device_status_leds_tb
`default_nettype wire
